// file: verilog/counter_array_consts.svh
// Summary of operation
// (R1) Once watchdog lock is set, watchdog stays enabled until system reset.
// (R2) Mode bit 4 reads zero and ignores writes.
// (R3) Timebase codes 000, 001, 100: clock divided by 12, by 4, undivided.
// (R4) Timebase code 010 advances once per Timer 0 overflow.
// (R5) Code 011 advances on falling external count input; source at most clock/4.
// (R6) Code 101 advances at external clock divided by 8, synchronized first.
// (R7) Overflow irq enable gates overflow request from the overflow flag.
// (R8) While watchdog enabled, writes to other mode bits are ignored.
// (R9) Watchdog enable at bit 6, reset 1, makes module 2 the watchdog.
// (R10) Idle suspend at bit 7 stops the array while processor idles.
// (R11) Reserved codes 110 and 111 select no source; counter stays still.
//
// Purpose: Constants of the counter array mode control block
// Assumes: APB word registers at byte offsets below
// Notes:   Included by its bare name
`ifndef COUNTER_ARRAY_CONSTS_SVH
`define COUNTER_ARRAY_CONSTS_SVH

`define OFS_MODE        12'h000
`define OFS_STATUS      12'h004
`define OFS_MASK        12'h008

`define MODE_RESET      8'h40
`define MODE_WRMASK     8'hef
`define BIT_IRQ_EN      0
`define BIT_SEL_LO      1
`define BIT_LOCK        5
`define BIT_WDOG        6
`define BIT_IDLE_SUSP   7

`define EV_OVERFLOW     0
`define EV_REFUSED      1
`define EV_WIDTH        2

`define DIV12_LAST      4'hb
`define DIV4_LAST       2'h3
`define EXT_DIV_LAST    3'h7

`endif

// file: verilog/counter_array_pkg.sv
// Purpose: Types of the counter array mode control block
// Assumes: Constants come from the header
// Notes:   Enum order gives the timebase codes 000 to 101
package counter_array_pkg;

   typedef enum logic [2:0] {
      TB_DIV12,
      TB_DIV4,
      TB_TIMER0,
      TB_ECI_FALL,
      TB_SYSCLK,
      TB_EXT_DIV8
   } timebase_t;

endpackage

// file: verilog/counter_array_mode_control.sv
// Purpose: Mode control and timebase selection of a counter array
// Assumes: MCLK 25 MHz, synchronous active high RESET, APB slave
// Notes:   External clock must stay well below MCLK/4
`timescale 1ns/1ns
`include "counter_array_consts.svh"

module counter_array_mode_control
   import counter_array_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input  wire logic              MCLK,
   input  wire logic              RESET,
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   input  wire logic              TIMER0_OVF,
   input  wire logic              EXTERNAL_COUNT_INPUT,
   input  wire logic              EXT_CLK,
   input  wire logic              COUNTER_OVERFLOW_FLAG,
   input  wire logic              CPU_IDLE,
   output logic                   COUNT_TICK,
   output logic                   WATCHDOG_ENABLE,
   output logic                   ARRAY_RUN,
   output logic                   OVERFLOW_REQ,
   output logic                   IRQ
);

   // Refused at elaboration: the map needs offsets up to 0x008
   if (ADDR_W < 4) begin : g_addr_w_check
      $error("ADDR_W too small for the register map");
   end

   //----------------------------------------------------------
   // Bus decode
   //----------------------------------------------------------
   logic        pready_r;
   logic        access_c;
   logic        wr_c;
   logic [11:0] ofs_c;
   logic        hit_c;

   assign access_c = PSEL && PENABLE && pready_r;
   assign wr_c     = access_c && PWRITE;
   assign ofs_c    = 12'(PADDR);
   assign hit_c    = (ofs_c == `OFS_MODE) || (ofs_c == `OFS_STATUS)
                  || (ofs_c == `OFS_MASK);

   //----------------------------------------------------------
   // Mode register
   //----------------------------------------------------------
   logic [7:0] mode_r;
   logic [7:0] mode_nxt;
   logic [7:0] wval_c;
   logic       wr_mode_c;
   logic       refused_c;

   assign wr_mode_c = wr_c && (ofs_c == `OFS_MODE);
   assign wval_c    = PWDATA[7:0] & `MODE_WRMASK;               // [R2]

   always_comb begin
      mode_nxt  = mode_r;
      refused_c = 1'b0;
      if (wr_mode_c) begin
         if (mode_r[`BIT_WDOG]) begin
            // Only the watchdog bits themselves stay writable
            mode_nxt[`BIT_WDOG] = wval_c[`BIT_WDOG];             // [R8]
            mode_nxt[`BIT_LOCK] = wval_c[`BIT_LOCK];
            refused_c = ((wval_c ^ mode_r) & 8'h9f) != 8'h00;
         end else begin
            mode_nxt = wval_c;
         end
         mode_nxt[`BIT_LOCK] = mode_nxt[`BIT_LOCK] | mode_r[`BIT_LOCK];
      end
      if (mode_nxt[`BIT_LOCK]) begin
         mode_nxt[`BIT_WDOG] = 1'b1;                             // [R1]
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         mode_r <= `MODE_RESET;                                  // [R9]
      end else begin
         mode_r <= mode_nxt;
      end
   end

   logic [2:0] sel_c;
   logic       run_c;
   assign sel_c = mode_r[`BIT_SEL_LO +: 3];
   assign run_c = !(mode_r[`BIT_IDLE_SUSP] && CPU_IDLE);        // [R10]

   //----------------------------------------------------------
   // Pin synchronisers
   //----------------------------------------------------------
   logic [2:0] eci_sy_r;
   logic [2:0] ext_sy_r;
   logic       eci_lvl_r;
   logic       ext_lvl_r;

   // A level changes only once stages two and three agree
   function automatic logic filt(input logic [2:0] s, input logic old);
      filt = (s[1] == s[2]) ? s[2] : old;
   endfunction

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         eci_sy_r  <= 3'h7;
         ext_sy_r  <= 3'h0;
         eci_lvl_r <= 1'b1;
         ext_lvl_r <= 1'b0;
      end else begin
         eci_sy_r  <= {eci_sy_r[1:0], EXTERNAL_COUNT_INPUT};
         ext_sy_r  <= {ext_sy_r[1:0], EXT_CLK};                  // [R6]
         eci_lvl_r <= filt(eci_sy_r, eci_lvl_r);
         ext_lvl_r <= filt(ext_sy_r, ext_lvl_r);
      end
   end

   logic eci_fall_c;
   logic ext_rise_c;
   assign eci_fall_c = eci_lvl_r && !filt(eci_sy_r, eci_lvl_r);  // [R5]
   assign ext_rise_c = !ext_lvl_r && filt(ext_sy_r, ext_lvl_r);

   //----------------------------------------------------------
   // Prescalers
   //----------------------------------------------------------
   logic [3:0] div12_r;
   logic [1:0] div4_r;
   logic [2:0] ext_cnt_r;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         div12_r <= 4'h0;
         div4_r  <= 2'h0;
      end else if (run_c) begin
         div12_r <= (div12_r == `DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
         div4_r  <= div4_r + 2'h1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ext_cnt_r <= 3'h0;
      end else if (ext_rise_c && run_c) begin
         ext_cnt_r <= ext_cnt_r + 3'h1;                          // [R6]
      end
   end

   //----------------------------------------------------------
   // Timebase selection
   //----------------------------------------------------------
   logic src_c;
   always_comb begin
      unique case (sel_c)
         TB_DIV12:    src_c = div12_r == `DIV12_LAST;            // [R3]
         TB_DIV4:     src_c = div4_r == `DIV4_LAST;              // [R3]
         TB_TIMER0:   src_c = TIMER0_OVF;                        // [R4]
         TB_ECI_FALL: src_c = eci_fall_c;                        // [R5]
         TB_SYSCLK:   src_c = 1'b1;                              // [R3]
         TB_EXT_DIV8: src_c = ext_rise_c && (ext_cnt_r == `EXT_DIV_LAST);
         default:     src_c = 1'b0;                              // [R11]
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         COUNT_TICK      <= 1'b0;
         ARRAY_RUN       <= 1'b1;
         WATCHDOG_ENABLE <= 1'b1;
         OVERFLOW_REQ    <= 1'b0;
      end else begin
         COUNT_TICK      <= src_c && run_c;                      // [R10]
         ARRAY_RUN       <= run_c;
         WATCHDOG_ENABLE <= mode_r[`BIT_WDOG];                   // [R9]
         OVERFLOW_REQ    <= mode_r[`BIT_IRQ_EN] && COUNTER_OVERFLOW_FLAG; // [R7]
      end
   end

   //----------------------------------------------------------
   // Interrupt status and mask
   //----------------------------------------------------------
   logic [`EV_WIDTH-1:0] stat_r;
   logic [`EV_WIDTH-1:0] mask_r;
   logic [`EV_WIDTH-1:0] ev_c;
   logic                 ovf_d_r;

   assign ev_c = {refused_c, COUNTER_OVERFLOW_FLAG && !ovf_d_r};

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         stat_r  <= '0;
         ovf_d_r <= 1'b0;
      end else begin
         ovf_d_r <= COUNTER_OVERFLOW_FLAG;
         // Set wins over a clear in the same cycle
         if (wr_c && ofs_c == `OFS_STATUS) begin
            stat_r <= (stat_r & ~PWDATA[`EV_WIDTH-1:0]) | ev_c;
         end else begin
            stat_r <= stat_r | ev_c;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         mask_r <= '0;
      end else if (wr_c && ofs_c == `OFS_MASK) begin
         mask_r <= PWDATA[`EV_WIDTH-1:0];
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         IRQ <= 1'b0;
      end else begin
         IRQ <= |(stat_r & mask_r);
      end
   end

   //----------------------------------------------------------
   // APB answer, one wait state
   //----------------------------------------------------------
   logic [31:0] rdata_c;
   always_comb begin
      rdata_c = 32'h0000_0000;
      if (ofs_c == `OFS_MODE) begin
         rdata_c[7:0] = mode_r;
      end else if (ofs_c == `OFS_STATUS) begin
         rdata_c[`EV_WIDTH-1:0] = stat_r;
      end else if (ofs_c == `OFS_MASK) begin
         rdata_c[`EV_WIDTH-1:0] = mask_r;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         pready_r <= 1'b0;
         PRDATA   <= 32'h0000_0000;
         PSLVERR  <= 1'b0;
      end else if (PSEL && PENABLE && !pready_r) begin
         pready_r <= 1'b1;
         PRDATA   <= PWRITE ? 32'h0000_0000 : rdata_c;
         PSLVERR  <= !hit_c;
      end else begin
         pready_r <= 1'b0;
         PSLVERR  <= 1'b0;
      end
   end
   assign PREADY = pready_r;

   //----------------------------------------------------------
   // Checks
   //----------------------------------------------------------
   // Tick must stem from the divider, not from the source before a switch
   sequence div12_tick_s;
      COUNT_TICK && sel_c == TB_DIV12 && run_c && $past(sel_c) == TB_DIV12;
   endsequence

   sequence mode_write_s;
      wr_mode_c && mode_r[`BIT_WDOG];
   endsequence

   lock_holds_a: assert property (@(posedge MCLK) disable iff (RESET) // [R1]
      mode_r[`BIT_LOCK] |=> mode_r[`BIT_LOCK] && WATCHDOG_ENABLE)
      else $error("watchdog dropped while locked");

   bit4_zero_a: assert property (@(posedge MCLK) disable iff (RESET) // [R2]
      (PREADY && !PWRITE && ofs_c == `OFS_MODE) |-> !PRDATA[4])
      else $error("mode bit 4 not zero");

   div12_gap_a: assert property (@(posedge MCLK) disable iff (RESET) // [R3]
      div12_tick_s ##1 (sel_c == TB_DIV12 && run_c)[*8] |-> !$past(COUNT_TICK))
      else $error("divide by 12 tick too soon");

   sysclk_tick_a: assert property (@(posedge MCLK) disable iff (RESET) // [R3]
      (sel_c == TB_SYSCLK && run_c) |=> COUNT_TICK)
      else $error("system clock tick missing");

   timer0_tick_a: assert property (@(posedge MCLK) disable iff (RESET) // [R4]
      (sel_c == TB_TIMER0 && run_c) |=> COUNT_TICK == $past(TIMER0_OVF))
      else $error("timer 0 tick mismatch");

   eci_tick_a: assert property (@(posedge MCLK) disable iff (RESET) // [R5]
      (sel_c == TB_ECI_FALL && run_c && eci_fall_c) |=> COUNT_TICK)
      else $error("external falling edge lost");

   ext8_tick_a: assert property (@(posedge MCLK) disable iff (RESET) // [R6]
      (sel_c == TB_EXT_DIV8 && $past(sel_c) == TB_EXT_DIV8 && COUNT_TICK)
         |-> $past(ext_cnt_r == `EXT_DIV_LAST))
      else $error("external divide by 8 wrong");

   irq_gate_a: assert property (@(posedge MCLK) disable iff (RESET) // [R7]
      ##1 OVERFLOW_REQ == $past(mode_r[`BIT_IRQ_EN] && COUNTER_OVERFLOW_FLAG))
      else $error("overflow request not gated");

   mode_frozen_a: assert property (@(posedge MCLK) disable iff (RESET) // [R8]
      mode_write_s |=> (mode_r & 8'h9f) == ($past(mode_r) & 8'h9f))
      else $error("mode changed while watchdog on");

   idle_stop_a: assert property (@(posedge MCLK) disable iff (RESET) // [R10]
      (mode_r[`BIT_IDLE_SUSP] && CPU_IDLE) |=> !COUNT_TICK && !ARRAY_RUN)
      else $error("array ran in idle");

   reserved_still_a: assert property (@(posedge MCLK) disable iff (RESET) // [R11]
      (sel_c[2:1] == 2'b11) |=> !COUNT_TICK)
      else $error("reserved code produced tick");

endmodule

// file: dv/tb.sv
// Purpose: Self-checking bench of the counter array mode control block
// Assumes: Registers at OFS_MODE, OFS_STATUS, OFS_MASK; APB slave answers with PREADY
// Notes:   Tick counts are taken over windows that are whole multiples of each divider
`timescale 1ns/1ns
`include "counter_array_consts.svh"

module tb
   import counter_array_pkg::*;
;
   logic        MCLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA;
   logic        TIMER0_OVF, EXTERNAL_COUNT_INPUT, EXT_CLK, COUNTER_OVERFLOW_FLAG, CPU_IDLE;
   logic        COUNT_TICK, WATCHDOG_ENABLE, ARRAY_RUN, OVERFLOW_REQ, IRQ;
   int          n_mismatch, num_checks, n;
   logic [31:0] r;
   logic        e;

   counter_array_mode_control dut_u (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .TIMER0_OVF(TIMER0_OVF), .EXTERNAL_COUNT_INPUT(EXTERNAL_COUNT_INPUT),
      .EXT_CLK(EXT_CLK), .COUNTER_OVERFLOW_FLAG(COUNTER_OVERFLOW_FLAG), .CPU_IDLE(CPU_IDLE),
      .COUNT_TICK(COUNT_TICK), .WATCHDOG_ENABLE(WATCHDOG_ENABLE), .ARRAY_RUN(ARRAY_RUN),
      .OVERFLOW_REQ(OVERFLOW_REQ), .IRQ(IRQ));

   // ----------------------------------------
   // Clock and shared tasks
   // ----------------------------------------
   always #20 MCLK = ~MCLK;

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // Holds the request until PREADY is sampled high
   // A hang here is ended only by the bench watchdog
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      PSEL <= 1'b1; PENABLE <= 1'b0; PWRITE <= w; PADDR <= a; PWDATA <= d;
      @(posedge MCLK);
      PENABLE <= 1'b1;
      do begin
         @(posedge MCLK);
      end while (PREADY !== 1'b1);
      r = PRDATA;
      e = PSLVERR;
      PSEL <= 1'b0; PENABLE <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(r, exp);
   endtask

   task automatic ticks(input int cyc);
      n = 0;
      repeat (cyc) begin
         @(posedge MCLK);
         if (COUNT_TICK === 1'b1) n++;
      end
   endtask

   task automatic sel_count(input logic [7:0] m, input int cyc, input int exp);
      apb(1'b1, `OFS_MODE, {24'h0, m});
      repeat (2) @(posedge MCLK);
      ticks(cyc);
      chk(n, exp);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset_and_locked_writes();
      rd(`OFS_MODE, 32'h40);
      chk(WATCHDOG_ENABLE, 1'b1);
      apb(1'b1, `OFS_MODE, 32'h4e);
      rd(`OFS_MODE, 32'h40);
      rd(`OFS_STATUS, 32'h2);
      apb(1'b1, `OFS_STATUS, 32'h2);
      rd(`OFS_STATUS, 32'h0);
      apb(1'b1, `OFS_MODE, 32'h10);
      rd(`OFS_MODE, 32'h0);
      chk(WATCHDOG_ENABLE, 1'b0);
      // Watchdog now off, so only the bit 4 mask can hold the bit low
      apb(1'b1, `OFS_MODE, 32'h10);
      rd(`OFS_MODE, 32'h0);
      chk(e, 1'b0);
   endtask

   task automatic t_timebases();
      sel_count(8'h00, 48, 4);
      sel_count(8'h02, 48, 12);
      sel_count(8'h08, 20, 20);
      sel_count(8'h0c, 30, 0);
      sel_count(8'h0e, 30, 0);
      apb(1'b1, `OFS_MODE, 32'h04);
      repeat (3) begin
         TIMER0_OVF <= 1'b1;
         @(posedge MCLK);
         TIMER0_OVF <= 1'b0;
         ticks(6);
      end
      ticks(4);
      chk(n, 0);
      // Source stays well under a quarter of the clock rate
      apb(1'b1, `OFS_MODE, 32'h06);
      fork
         repeat (3) begin
            EXTERNAL_COUNT_INPUT <= 1'b0;
            repeat (6) @(posedge MCLK);
            EXTERNAL_COUNT_INPUT <= 1'b1;
            repeat (6) @(posedge MCLK);
         end
         ticks(46);
      join
      chk(n, 3);
      apb(1'b1, `OFS_MODE, 32'h0a);
      fork
         repeat (16) begin
            EXT_CLK <= 1'b1;
            repeat (5) @(posedge MCLK);
            EXT_CLK <= 1'b0;
            repeat (5) @(posedge MCLK);
         end
         ticks(175);
      join
      chk(n, 2);
   endtask

   task automatic t_timer0_count();
      apb(1'b1, `OFS_MODE, 32'h04);
      fork
         repeat (3) begin
            TIMER0_OVF <= 1'b1;
            @(posedge MCLK);
            TIMER0_OVF <= 1'b0;
            repeat (5) @(posedge MCLK);
         end
         ticks(22);
      join
      chk(n, 3);
   endtask

   task automatic t_idle_and_irq();
      CPU_IDLE <= 1'b1;
      sel_count(8'h88, 20, 0);
      chk(ARRAY_RUN, 1'b0);
      CPU_IDLE <= 1'b0;
      repeat (2) @(posedge MCLK);
      chk(ARRAY_RUN, 1'b1);
      ticks(10);
      chk(n, 10);
      apb(1'b1, `OFS_MASK, 32'h1);
      COUNTER_OVERFLOW_FLAG <= 1'b1;
      repeat (4) @(posedge MCLK);
      chk(OVERFLOW_REQ, 1'b0);
      chk(IRQ, 1'b1);
      apb(1'b1, `OFS_MODE, 32'h01);
      repeat (2) @(posedge MCLK);
      chk(OVERFLOW_REQ, 1'b1);
      COUNTER_OVERFLOW_FLAG <= 1'b0;
      apb(1'b1, `OFS_STATUS, 32'h1);
      repeat (2) @(posedge MCLK);
      chk(IRQ, 1'b0);
      chk(OVERFLOW_REQ, 1'b0);
      rd(`OFS_STATUS, 32'h0);
   endtask

   task automatic t_lock();
      apb(1'b1, `OFS_MODE, 32'h20);
      rd(`OFS_MODE, 32'h60);
      apb(1'b1, `OFS_MODE, 32'h00);
      rd(`OFS_MODE, 32'h60);
      chk(WATCHDOG_ENABLE, 1'b1);
      RESET <= 1'b1;
      repeat (4) @(posedge MCLK);
      RESET <= 1'b0;
      @(posedge MCLK);
      apb(1'b1, `OFS_MODE, 32'h00);
      rd(`OFS_MODE, 32'h0);
      apb(1'b0, 12'h00c, 32'h0);
      chk(e, 1'b1);
   endtask

   // ----------------------------------------
   // Main sequence and watchdog
   // ----------------------------------------
   initial begin
      MCLK = 0; RESET = 1; PSEL = 0; PENABLE = 0; PWRITE = 0; PADDR = '0; PWDATA = '0;
      TIMER0_OVF = 0; EXTERNAL_COUNT_INPUT = 1; EXT_CLK = 0; COUNTER_OVERFLOW_FLAG = 0;
      CPU_IDLE = 0; n_mismatch = 0; num_checks = 0;
      repeat (4) @(posedge MCLK);
      RESET <= 1'b0;
      @(posedge MCLK);
      t_reset_and_locked_writes();
      t_timebases();
      t_timer0_count();
      t_idle_and_irq();
      t_lock();
      tally_and_finish();
   end

   // Whole run needs roughly 630 cycles
   initial begin
      #400000;
      n_mismatch++;
      tally_and_finish();
   end
endmodule
